// ---- common/rsr_pkg.sv ----
// constants and carriers for the reset, strap and reference select block
// assumes one 200 MHz clock and an 8-bit register port at byte offsets
package rsr_pkg;
  // clock rate and reset hold time
  localparam int unsigned CLK_MHZ      = 200;
  localparam int unsigned HOLD_TIME_MS = 500;
  localparam int unsigned HOLD_CYC     = HOLD_TIME_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W        = 27;
  // register offsets
  localparam logic [7:0] ADR_NOM_LO  = 8'h04;
  localparam logic [7:0] ADR_NOM_MID = 8'h05;
  localparam logic [7:0] ADR_NOM_HI  = 8'h06;
  localparam logic [7:0] ADR_IN_MODE = 8'h09;
  localparam logic [7:0] ADR_SW_CNFG = 8'h0B;
  localparam logic [7:0] ADR_SEL     = 8'h10;
  localparam logic [7:0] ADR_LOOP    = 8'h11;
  localparam logic [7:0] ADR_STATUS  = 8'h12;
  // field positions
  localparam int unsigned RATE_BIT   = 2;
  localparam int unsigned FAST_BIT   = 4;
  // loop filter step limits
  localparam logic [3:0] BW_MAX      = 4'hA;
  localparam logic [2:0] DAMP_MAX    = 3'h4;
  // calibration limit, units of 0.0001 ppm
  localparam logic signed [23:0] CAL_MAX = 24'sh711150;
  localparam logic signed [23:0] CAL_MIN = -24'sh711150;
  // values after reset
  localparam logic [23:0] NOM_RST    = 24'h000000;
  localparam logic [7:0]  SEL_RST    = 8'h00;
  localparam logic [3:0]  BW_RST     = 4'h0;
  localparam logic [2:0]  DAMP_RST   = 3'h0;

  typedef enum logic [1:0] {
    RSR_FREE = 2'b00,
    RSR_LOCK = 2'b01,
    RSR_HOLD = 2'b10
  } rsr_mode_t;

  // forced mode codes in the select register
  localparam logic [1:0] FORCE_AUTO = 2'h0;
  localparam logic [1:0] FORCE_FREE = 2'h1;
  localparam logic [1:0] FORCE_LOCK = 2'h2;
  localparam logic [1:0] FORCE_HOLD = 2'h3;

  typedef struct packed {
    logic       manual;
    logic       manual_two;
    logic [1:0] forced;
    logic [3:0] bw;
    logic [2:0] damp;
  } rsr_cfg_t;
endpackage

// ---- hdl/rsr_top.sv ----
// reset hold, strap capture, reference select and loop mode control
// assumes pins and register port synchronous to the 200 MHz clk
`timescale 1ns/100ps
module rsr_top #(
  parameter int unsigned HOLD_CYC = rsr_pkg::HOLD_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        fast_ref_pick_pin,
  input  wire logic        rate_family_strap_pin,
  input  wire logic        diff_ref_one_ok,
  input  wire logic        diff_ref_two_ok,
  input  wire logic [23:0] trk_freq_word,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [7:0]  reg_rdata,
  output logic             in_reset,
  output logic             ref_two_sel,
  output logic      [1:0]  loop_mode,
  output logic      [23:0] loop_freq_word,
  output logic      [3:0]  loop_bw,
  output logic      [2:0]  loop_damp,
  output logic             rate_family_select
);
  localparam logic [rsr_pkg::CNT_W-1:0] HOLD_LAST =
    rsr_pkg::CNT_W'(HOLD_CYC - 1);

  logic [rsr_pkg::CNT_W-1:0] hold_cnt_ff;
  logic                      in_reset_ff;
  logic                      fast_en_ff;
  logic                      rate_ff;
  logic [23:0]               nom_ff;
  rsr_pkg::rsr_cfg_t         cfg_ff;
  rsr_pkg::rsr_mode_t        mode_ff;
  rsr_pkg::rsr_mode_t        nxt_mode;
  logic                      ref_two_ff;
  logic                      nxt_ref_two;
  logic [23:0]               hold_word_ff;
  logic [23:0]               freq_ff;
  logic [7:0]                rdata_ff;
  logic                      sel_ok;
  logic                      wr_ok;

  // clamp a signed calibration word to the allowed span
  function automatic logic [23:0] cal_clamp(input logic [23:0] raw);
    if ($signed(raw) > rsr_pkg::CAL_MAX) begin
      cal_clamp = rsr_pkg::CAL_MAX;
    end else if ($signed(raw) < rsr_pkg::CAL_MIN) begin
      cal_clamp = rsr_pkg::CAL_MIN;
    end else begin
      cal_clamp = raw;
    end
  endfunction

  // writes are dropped while the block is still held in reset
  assign wr_ok  = reg_we && !in_reset_ff;
  assign sel_ok = ref_two_ff ? diff_ref_two_ok : diff_ref_one_ok;

  // internal reset: held while pin low, then a fixed hold count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_cnt_ff <= '0;
      in_reset_ff <= 1'b1;
    end else if (in_reset_ff) begin
      if (hold_cnt_ff == HOLD_LAST) begin
        in_reset_ff <= 1'b0;
      end else begin
        hold_cnt_ff <= hold_cnt_ff + 1'b1;
      end
    end
  end

  // strap bits track the pins until release, then only software writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fast_en_ff <= 1'b0;
      rate_ff    <= 1'b0;
    end else if (in_reset_ff) begin
      fast_en_ff <= fast_ref_pick_pin;
      rate_ff    <= rate_family_strap_pin;
    end else begin
      if (wr_ok && reg_addr == rsr_pkg::ADR_SW_CNFG) begin
        fast_en_ff <= reg_wdata[rsr_pkg::FAST_BIT];
      end
      if (wr_ok && reg_addr == rsr_pkg::ADR_IN_MODE) begin
        rate_ff <= reg_wdata[rsr_pkg::RATE_BIT];
      end
    end
  end

  // calibration word, three byte registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nom_ff <= rsr_pkg::NOM_RST;
    end else if (wr_ok) begin
      unique case (reg_addr)
        rsr_pkg::ADR_NOM_LO:  nom_ff[7:0]   <= reg_wdata;
        rsr_pkg::ADR_NOM_MID: nom_ff[15:8]  <= reg_wdata;
        rsr_pkg::ADR_NOM_HI:  nom_ff[23:16] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // selection and loop filter settings; out of range steps saturate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_ff <= {rsr_pkg::SEL_RST[3:0], rsr_pkg::BW_RST, rsr_pkg::DAMP_RST};
    end else if (wr_ok && reg_addr == rsr_pkg::ADR_SEL) begin
      cfg_ff.manual     <= reg_wdata[0];
      cfg_ff.manual_two <= reg_wdata[1];
      cfg_ff.forced     <= reg_wdata[3:2];
    end else if (wr_ok && reg_addr == rsr_pkg::ADR_LOOP) begin
      cfg_ff.bw   <= (reg_wdata[3:0] > rsr_pkg::BW_MAX) ?
                     rsr_pkg::BW_MAX : reg_wdata[3:0];
      cfg_ff.damp <= (reg_wdata[6:4] > rsr_pkg::DAMP_MAX) ?
                     rsr_pkg::DAMP_MAX : reg_wdata[6:4];
    end
  end

  // reference choice: fast pin, then manual, then automatic fallback
  always_comb begin
    nxt_ref_two = ref_two_ff;
    if (fast_en_ff) begin
      nxt_ref_two = !fast_ref_pick_pin;
    end else if (cfg_ff.manual) begin
      nxt_ref_two = cfg_ff.manual_two;
    end else if (diff_ref_one_ok) begin
      nxt_ref_two = 1'b0;
    end else if (diff_ref_two_ok) begin
      nxt_ref_two = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || in_reset_ff) begin
      ref_two_ff <= 1'b0;
    end else begin
      ref_two_ff <= nxt_ref_two;
    end
  end

  // loop mode machine; forced codes override the automatic path
  always_comb begin
    nxt_mode = mode_ff;
    unique case (cfg_ff.forced)
      rsr_pkg::FORCE_FREE: nxt_mode = rsr_pkg::RSR_FREE;
      rsr_pkg::FORCE_LOCK: nxt_mode = rsr_pkg::RSR_LOCK;
      rsr_pkg::FORCE_HOLD: nxt_mode = rsr_pkg::RSR_HOLD;
      rsr_pkg::FORCE_AUTO: begin
        unique case (mode_ff)
          rsr_pkg::RSR_FREE: if (sel_ok) nxt_mode = rsr_pkg::RSR_LOCK;
          rsr_pkg::RSR_LOCK: if (!sel_ok) nxt_mode = rsr_pkg::RSR_HOLD;
          rsr_pkg::RSR_HOLD: if (sel_ok) nxt_mode = rsr_pkg::RSR_LOCK;
          default:           nxt_mode = rsr_pkg::RSR_FREE;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n || in_reset_ff) begin
      mode_ff <= rsr_pkg::RSR_FREE;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // holdover keeps the last word seen while locked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_word_ff <= rsr_pkg::NOM_RST;
    end else if (mode_ff == rsr_pkg::RSR_LOCK) begin
      hold_word_ff <= trk_freq_word;
    end
  end

  // frequency word handed to the loop, registered for a clean output
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      freq_ff <= rsr_pkg::NOM_RST;
    end else begin
      unique case (mode_ff)
        rsr_pkg::RSR_LOCK: freq_ff <= trk_freq_word;
        rsr_pkg::RSR_HOLD: freq_ff <= hold_word_ff;
        default:           freq_ff <= cal_clamp(nom_ff);
      endcase
    end
  end

  // read data valid only in the cycle after the strobe, else zero
  always_ff @(posedge clk) begin
    if (!rst_n || !reg_re) begin
      rdata_ff <= 8'h00;
    end else begin
      unique case (reg_addr)
        rsr_pkg::ADR_NOM_LO:  rdata_ff <= nom_ff[7:0];
        rsr_pkg::ADR_NOM_MID: rdata_ff <= nom_ff[15:8];
        rsr_pkg::ADR_NOM_HI:  rdata_ff <= nom_ff[23:16];
        rsr_pkg::ADR_IN_MODE: rdata_ff <= {5'h00, rate_ff, 2'h0};
        rsr_pkg::ADR_SW_CNFG: rdata_ff <= {3'h0, fast_en_ff, 4'h0};
        rsr_pkg::ADR_SEL:     rdata_ff <= {4'h0, cfg_ff.forced,
                                           cfg_ff.manual_two, cfg_ff.manual};
        rsr_pkg::ADR_LOOP:    rdata_ff <= {1'b0, cfg_ff.damp, cfg_ff.bw};
        rsr_pkg::ADR_STATUS:  rdata_ff <= {3'h0, diff_ref_two_ok,
                                           diff_ref_one_ok, mode_ff,
                                           ref_two_ff};
        default:              rdata_ff <= 8'h00; // unmapped reads zero
      endcase
    end
  end

  // every output straight from a flip-flop, all on clk
  assign reg_rdata          = rdata_ff;
  assign in_reset           = in_reset_ff;
  assign ref_two_sel        = ref_two_ff;
  assign loop_mode          = mode_ff;
  assign loop_freq_word     = freq_ff;
  assign loop_bw            = cfg_ff.bw;
  assign loop_damp          = cfg_ff.damp;
  assign rate_family_select = rate_ff;

  // checks beside the logic
  sequence rel_seq;
    in_reset_ff ##1 !in_reset_ff;
  endsequence

  hold_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    rel_seq |-> $past(hold_cnt_ff, 1) == HOLD_LAST)
    else $error("reset released before hold count ended");

  hold_low_a: assert property (@(posedge clk)
    !rst_n |=> in_reset_ff && hold_cnt_ff == '0)
    else $error("low reset pin did not hold reset");

  fast_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    rel_seq |-> fast_en_ff == $past(fast_ref_pick_pin, 1))
    else $error("fast enable not taken from pin at release");

  rate_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    rel_seq |-> rate_ff == $past(rate_family_strap_pin, 1))
    else $error("rate family not taken from strap at release");

  rate_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    !in_reset_ff && !(reg_we && reg_addr == rsr_pkg::ADR_IN_MODE)
    |=> $stable(rate_ff))
    else $error("rate family changed without a write");

  fast_pick_a: assert property (@(posedge clk) disable iff (!rst_n)
    !in_reset_ff && fast_en_ff |=> ref_two_ff == !$past(fast_ref_pick_pin))
    else $error("fast pin did not pick the reference");

  fast_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !in_reset_ff && !fast_en_ff && cfg_ff.manual
    |=> ref_two_ff == $past(cfg_ff.manual_two))
    else $error("manual pick overridden by fast pin");

  // locked in one cycle, holdover in the next: the saved word must follow
  sequence lock_hold_seq;
    mode_ff == rsr_pkg::RSR_LOCK ##1 mode_ff == rsr_pkg::RSR_HOLD;
  endsequence

  hold_data_a: assert property (@(posedge clk) disable iff (!rst_n)
    lock_hold_seq |=> freq_ff == $past(trk_freq_word, 2))
    else $error("holdover word not the last locked word");

  // a forced holdover code wins over the automatic path at the next edge
  force_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    rst_n && !in_reset_ff && cfg_ff.forced == rsr_pkg::FORCE_HOLD
    |=> mode_ff == rsr_pkg::RSR_HOLD)
    else $error("forced holdover not taken");

  bw_lim_a: assert property (@(posedge clk) disable iff (!rst_n)
    cfg_ff.bw <= rsr_pkg::BW_MAX && cfg_ff.damp <= rsr_pkg::DAMP_MAX)
    else $error("loop step code out of range");

  cal_lim_a: assert property (@(posedge clk) disable iff (!rst_n)
    mode_ff == rsr_pkg::RSR_FREE |=> $signed(freq_ff) <= rsr_pkg::CAL_MAX
    && $signed(freq_ff) >= rsr_pkg::CAL_MIN)
    else $error("calibration word beyond limit");

  rd_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_re |=> rdata_ff == 8'h00)
    else $error("read data outside answer cycle");
endmodule // rsr_top

// ---- tb/rsr_board_model.sv ----
// board controller model: drives the reset pin and the two strap pins
// assumes the bench pulses start_rst for one clk cycle to begin a reset
`timescale 1ns/100ps
module rsr_board_model #(
  parameter int unsigned LOW_CYC = 10000
) (
  input  wire logic clk,
  input  wire logic start_rst,
  input  wire logic fast_lvl,
  input  wire logic rate_lvl,
  output logic      rst_n,
  output logic      fast_ref_pick_pin,
  output logic      rate_family_strap_pin
);
  int unsigned low_cnt_ff = LOW_CYC;
  logic        rst_n_ff   = 1'b0;
  logic        fast_ff    = 1'b0;
  logic        rate_ff    = 1'b0;

  // reset held low for the whole 50 us, shorter pulses never leave here
  always_ff @(posedge clk) begin
    if (start_rst) begin
      low_cnt_ff <= LOW_CYC;
      rst_n_ff   <= 1'b0;
    end else if (low_cnt_ff != 0) begin
      low_cnt_ff <= low_cnt_ff - 1;
    end else begin
      rst_n_ff <= 1'b1;
    end
  end

  // straps move only just after an edge, like a real controller
  always_ff @(posedge clk) begin
    fast_ff <= fast_lvl;
    rate_ff <= rate_lvl;
  end

  assign rst_n                 = rst_n_ff;
  assign fast_ref_pick_pin     = fast_ff;
  assign rate_family_strap_pin = rate_ff;
endmodule // rsr_board_model

// ---- tb/rsr_top_bench.sv ----
// self-checking bench for the reset, strap and reference select block
// assumes the board model above and a hold count shortened to 20 cycles
`timescale 1ns/100ps
module rsr_top_bench;
  localparam int unsigned HOLD = 20;
  logic        clk       = 1'b0;
  logic        start_rst = 1'b0;
  logic        fast_lvl  = 1'b1;
  logic        rate_lvl  = 1'b1;
  logic        one_ok    = 1'b0;
  logic        two_ok    = 1'b0;
  logic [23:0] trk       = 24'h000000;
  logic [7:0]  addr      = 8'h00;
  logic [7:0]  wdata     = 8'h00;
  logic        we        = 1'b0;
  logic        re        = 1'b0;
  logic        rst_n, fast_pin, rate_pin, in_reset, ref_two, rate_sel;
  logic [7:0]  rdata;
  logic [1:0]  mode;
  logic [23:0] freq;
  logic [3:0]  bw;
  logic [2:0]  damp;
  int          errors    = 0;
  int          cmp_count = 0;

  // 200 MHz
  always #2.5 clk = ~clk;

  rsr_board_model board (.clk(clk), .start_rst(start_rst),
    .fast_lvl(fast_lvl), .rate_lvl(rate_lvl), .rst_n(rst_n),
    .fast_ref_pick_pin(fast_pin), .rate_family_strap_pin(rate_pin));

  rsr_top #(.HOLD_CYC(HOLD)) DUT (.clk(clk), .rst_n(rst_n),
    .fast_ref_pick_pin(fast_pin), .rate_family_strap_pin(rate_pin),
    .diff_ref_one_ok(one_ok), .diff_ref_two_ok(two_ok),
    .trk_freq_word(trk), .reg_addr(addr), .reg_wdata(wdata),
    .reg_we(we), .reg_re(re), .reg_rdata(rdata), .in_reset(in_reset),
    .ref_two_sel(ref_two), .loop_mode(mode), .loop_freq_word(freq),
    .loop_bw(bw), .loop_damp(damp), .rate_family_select(rate_sel));

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // one-cycle write strobe; effect lands at the sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    we    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
    #1;
  endtask

  // read data only stands in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge clk);
    re   <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    check({16'h0000, rdata}, {16'h0000, exp}, what);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // full reset through the board model, then time the internal hold
  task automatic do_reset();
    int n;
    @(posedge clk);
    start_rst <= 1'b1;
    @(posedge clk);
    start_rst <= 1'b0;
    wait_cyc(100);
    check({23'h0, in_reset}, 24'h1, "held in reset");
    n = 0;
    while (rst_n !== 1'b1 && n < 20000) begin
      wait_cyc(1);
      n++;
    end
    if (n >= 20000) begin
      errors++;
      $display("FAIL %0t reset pin never released", $time);
      end_of_test();
    end
    // pin seen high just after edge r; internal reset ends at edge r+HOLD
    wait_cyc(HOLD - 1);
    check({23'h0, in_reset}, 24'h1, "hold too short");
    wait_cyc(1);
    check({23'h0, in_reset}, 24'h0, "hold too long");
  endtask

  initial begin
    do_reset();
    check({23'h0, rate_sel}, 24'h1, "rate strap high");
    rd_chk(rsr_pkg::ADR_SW_CNFG, 8'h10, "fast enable set");
    rd_chk(rsr_pkg::ADR_IN_MODE, 8'h04, "rate bit set");
    rate_lvl <= 1'b0;
    wait_cyc(4);
    check({23'h0, rate_sel}, 24'h1, "strap ignored");
    wr(rsr_pkg::ADR_IN_MODE, 8'h00);
    check({23'h0, rate_sel}, 24'h0, "rate by write");
    fast_lvl <= 1'b0;
    wait_cyc(4);
    check({23'h0, ref_two}, 24'h1, "pin low picks two");
    fast_lvl <= 1'b1;
    wait_cyc(4);
    check({23'h0, ref_two}, 24'h0, "pin high picks one");
    // codes above the last step saturate
    wr(rsr_pkg::ADR_LOOP, 8'hFF);
    check({17'h0, bw, damp}, {17'h0, rsr_pkg::BW_MAX, rsr_pkg::DAMP_MAX},
          "step limits");
    rd_chk(8'h20, 8'h00, "unmapped read");
    // calibration beyond the range is clamped, raw value reads back
    wr(rsr_pkg::ADR_NOM_LO, 8'hFF);
    wr(rsr_pkg::ADR_NOM_MID, 8'hFF);
    wr(rsr_pkg::ADR_NOM_HI, 8'h7F);
    wr(rsr_pkg::ADR_SEL, 8'h04);
    wait_cyc(3);
    check({22'h0, mode}, {22'h0, rsr_pkg::RSR_FREE}, "forced free");
    check(freq, rsr_pkg::CAL_MAX, "calibration clamp");
    rd_chk(rsr_pkg::ADR_NOM_HI, 8'h7F, "raw calibration");
    // negative overflow clamps low, an in-range word passes untouched
    wr(rsr_pkg::ADR_NOM_HI, 8'h80);
    wait_cyc(3);
    check(freq, rsr_pkg::CAL_MIN, "negative clamp");
    wr(rsr_pkg::ADR_NOM_HI, 8'h00);
    wait_cyc(3);
    check(freq, 24'h00FFFF, "in range passes");
    // second reset with both straps low and ref one usable
    @(posedge clk);
    fast_lvl <= 1'b0;
    rate_lvl <= 1'b0;
    one_ok   <= 1'b1;
    trk      <= 24'h123456;
    do_reset();
    check({23'h0, rate_sel}, 24'h0, "rate strap low");
    rd_chk(rsr_pkg::ADR_SW_CNFG, 8'h00, "fast enable clear");
    rd_chk(rsr_pkg::ADR_LOOP, 8'h00, "loop reg default");
    wait_cyc(4);
    check({23'h0, ref_two}, 24'h0, "pin ignored");
    check({22'h0, mode}, {22'h0, rsr_pkg::RSR_LOCK}, "auto lock");
    check(freq, 24'h123456, "tracks input");
    @(posedge clk);
    one_ok <= 1'b0;
    wait_cyc(4);
    @(posedge clk);
    trk <= 24'h00ABCD;
    wait_cyc(4);
    check({22'h0, mode}, {22'h0, rsr_pkg::RSR_HOLD}, "holdover");
    check(freq, 24'h123456, "held word");
    wr(rsr_pkg::ADR_SEL, 8'h03);
    wait_cyc(3);
    check({23'h0, ref_two}, 24'h1, "manual pick two");
    // forced codes: lock follows the live word, holdover keeps it
    wr(rsr_pkg::ADR_SEL, 8'h08);
    wait_cyc(3);
    check({22'h0, mode}, {22'h0, rsr_pkg::RSR_LOCK}, "forced lock");
    check(freq, 24'h00ABCD, "forced lock tracks");
    rd_chk(rsr_pkg::ADR_SEL, 8'h08, "select readback");
    rd_chk(rsr_pkg::ADR_STATUS, 8'h03, "status word");
    wr(rsr_pkg::ADR_SEL, 8'h0C);
    wait_cyc(3);
    check({22'h0, mode}, {22'h0, rsr_pkg::RSR_HOLD}, "forced hold");
    check(freq, 24'h00ABCD, "forced hold word");
    end_of_test();
  end
endmodule // rsr_top_bench
